// [include/irq_ctrl_map.vh]
// Register offsets, field positions, reset values and timing counts of the interrupt controller
`ifndef IRQ_CTRL_MAP_VH
`define IRQ_CTRL_MAP_VH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define IRQ_ENABLE_OFFSET 12'h000
`define IRQ_LEVEL_OFFSET 12'h004
`define IRQ_STATUS_OFFSET 12'h008
`define IRQ_CORE_OFFSET 12'h00c
`define IRQ_PC_OFFSET 12'h010
`define IRQ_STACK_OFFSET 12'h014

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define GLOBAL_IRQ_ENABLE_BIT 7
`define SERIAL_BIT 4
`define TIMER1_BIT 3
`define EXT1_BIT 2
`define TIMER0_BIT 1
`define EXT0_BIT 0
`define CORE_RETURN_BIT 0
`define CORE_STEP_BIT 1

// ----------------------------------------------------------------
// Reset values and masks
// ----------------------------------------------------------------
`define IRQ_ENABLE_RESET 8'h00
`define IRQ_LEVEL_RESET 8'h00
`define IRQ_ENABLE_MASK 8'h9f
`define IRQ_LEVEL_MASK 8'h1f
`define PC_RESET 16'h0000

// ----------------------------------------------------------------
// Vector addresses
// ----------------------------------------------------------------
`define VEC_EXT0 16'h0003
`define VEC_TIMER0 16'h000b
`define VEC_EXT1 16'h0013
`define VEC_TIMER1 16'h001b
`define VEC_SERIAL 16'h0023

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define OSC_PER_PHASE 1
`define PHASES_PER_STATE 2
`define STATES_PER_CYCLE 6
`define SAMPLE_STATE 5

`endif

// [verilog/machine_cycle_timer.v]
// Machine cycle state and phase generator
`timescale 1ns/1ps
module machine_cycle_timer
(
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Timing outputs
    output reg [2:0] state_num,
    output reg phase2,
    output wire sample_pulse,
    output wire cycle_end
);
`include "irq_ctrl_map.vh"

    // ----------------------------------------------------------------
    // Six states of two phases, one oscillator period each
    // ----------------------------------------------------------------
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_num <= 3'h1;
            phase2 <= 1'b0;
        end
        else if (phase2)
        begin
            phase2 <= 1'b0; // R19
            if (state_num == `STATES_PER_CYCLE)
                state_num <= 3'h1; // R18
            else
                state_num <= state_num + 3'h1;
        end
        else
        begin
            phase2 <= 1'b1;
        end
    end

    // Capture at end of state 5
    assign sample_pulse = phase2 && (state_num == `SAMPLE_STATE); // R12
    assign cycle_end = phase2 && (state_num == `STATES_PER_CYCLE);
endmodule

// [verilog/return_stack.v]
// Small stack memory holding pushed program counters
`timescale 1ns/1ps
module return_stack
#(
    parameter DEPTH_LOG2 = 3
)
(
    // Clock
    input wire aclk,
    // Write port
    input wire wr_en,
    input wire [DEPTH_LOG2-1:0] wr_addr,
    input wire [15:0] wr_data,
    // Read port
    input wire [DEPTH_LOG2-1:0] rd_addr,
    output reg [15:0] rd_data
);
    reg [15:0] mem [0:(1<<DEPTH_LOG2)-1];

    always @(posedge aclk)
    begin
        if (wr_en)
            mem[wr_addr] <= wr_data;
        rd_data <= mem[rd_addr];
    end
endmodule

// [verilog/vectored_irq_controller.v]
// Two-level vectored interrupt controller with AXI4-Lite registers
// Contract
// R1: Five request sources: two external, two timers, serial
// R2: Each source has own enable bit
// R3: Bit 7 global enable gates all acknowledges
// R4: Enable bits serial4 t1 3 x1 2 t0 1 x0 0
// R5: Level register, same bit layout, two levels
// R6: High preempts low; low never preempts low
// R7: High routine in progress blocks all vectoring
// R8: Higher level wins among simultaneous requests
// R9: Fixed polling picks one within a level
// R10: Poll order ext0, timer0, ext1, timer1, serial
// R11: Level bit one means high level
// R12: Flags captured state 5, evaluated next cycle; code evaluates at state 6 of the same cycle
// R13: Enabled unblocked flag injects hardware vector call
// R14: Hold off while equal/higher level in progress
// R15: Call pushes PC, loads fixed vector address
// R16: Vectors 03, 0B, 13, 1B, 23 hex
// R17: Only program counter saved on vectoring
// R18: Machine cycle six states, twelve oscillator periods
// R19: Each state has two one-period phases
// R20: Return clears active in-progress; else plain return
//
// Design decisions made here: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
module vectored_irq_controller
#(
    parameter STACK_LOG2 = 3
)
(
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Request flags
    input wire ext0_req,
    input wire timer0_req,
    input wire ext1_req,
    input wire timer1_req,
    input wire serial_req,
    // Core side
    input wire return_from_irq,
    output reg hw_vector_call,
    output reg [2:0] vector_source,
    output reg [15:0] pc_out,
    output reg [15:0] pushed_pc,
    output wire [2:0] machine_state,
    output wire machine_phase2,
    // AXI4-Lite write address
    input wire [11:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    // AXI4-Lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // AXI4-Lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read address
    input wire [11:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    // AXI4-Lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready
);
`include "irq_ctrl_map.vh"

    localparam [1:0] RESP_OKAY = 2'b00;
    localparam [1:0] RESP_SLVERR = 2'b10;
    localparam [2:0] NO_SOURCE = 3'h7;

    // ----------------------------------------------------------------
    // Helper functions
    // ----------------------------------------------------------------
    // First set bit in polling order, NO_SOURCE when none
    function [2:0] poll_pick;
        input [4:0] req;
        begin
            if (req[`EXT0_BIT])
                poll_pick = 3'h0; // R10
            else if (req[`TIMER0_BIT])
                poll_pick = 3'h1;
            else if (req[`EXT1_BIT])
                poll_pick = 3'h2;
            else if (req[`TIMER1_BIT])
                poll_pick = 3'h3;
            else if (req[`SERIAL_BIT])
                poll_pick = 3'h4;
            else
                poll_pick = NO_SOURCE;
        end
    endfunction

    function [15:0] vector_of;
        input [2:0] src;
        begin
            case (src)
                3'h0: vector_of = `VEC_EXT0; // R16
                3'h1: vector_of = `VEC_TIMER0;
                3'h2: vector_of = `VEC_EXT1;
                3'h3: vector_of = `VEC_TIMER1;
                default: vector_of = `VEC_SERIAL;
            endcase
        end
    endfunction

    function [7:0] merge_byte;
        input [7:0] old_val;
        input [7:0] new_val;
        input strobe;
        input [7:0] mask;
        begin
            merge_byte = strobe ? (new_val & mask) : old_val;
        end
    endfunction

    // ----------------------------------------------------------------
    // Machine cycle timing
    // ----------------------------------------------------------------
    wire sample_pulse;
    wire cycle_end;

    machine_cycle_timer u_timer
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .state_num(machine_state),
        .phase2(machine_phase2),
        .sample_pulse(sample_pulse),
        .cycle_end(cycle_end)
    );

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    reg [7:0] interrupt_enable_reg;
    reg [7:0] interrupt_priority_reg;
    reg [4:0] sampled_r;
    reg sample_valid_r;
    reg low_active_r;
    reg high_active_r;
    reg [STACK_LOG2-1:0] sp_r;
    reg step_pending_r;

    wire global_irq_enable = interrupt_enable_reg[`GLOBAL_IRQ_ENABLE_BIT];
    wire [4:0] source_enable = interrupt_enable_reg[4:0];
    wire [4:0] source_level = interrupt_priority_reg[4:0];

    // Requests capture in state 5, then are judged at the end of the same cycle
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sampled_r <= 5'h00;
            sample_valid_r <= 1'b0;
        end
        else if (sample_pulse)
        begin
            sampled_r <= {serial_req, timer1_req, ext1_req, timer0_req, ext0_req}; // R1 R12
            sample_valid_r <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Arbitration
    // ----------------------------------------------------------------
    wire [4:0] enabled_req = sampled_r & source_enable & {5{global_irq_enable}}; // R2 R3
    wire [4:0] high_req = enabled_req & source_level; // R11
    wire [4:0] low_req = enabled_req & ~source_level;
    wire [2:0] high_pick = poll_pick(high_req); // R9
    wire [2:0] low_pick = poll_pick(low_req);
    // Low may only start when nothing runs; high only when no high runs
    wire high_ok = !high_active_r && (high_pick != NO_SOURCE); // R6 R7 R14
    wire low_ok = !high_active_r && !low_active_r && (low_pick != NO_SOURCE); // R14
    wire [2:0] winner = high_ok ? high_pick : low_pick; // R8
    // Evaluation happens at the sixth state of the same cycle as the capture
    wire eval_now = cycle_end && sample_valid_r && (high_ok || low_ok); // R12 R13
    wire ret_now = return_from_irq && !eval_now;

    // Stack pointer wraps; software keeps nesting within depth
    wire [STACK_LOG2-1:0] sp_dec = sp_r - {{(STACK_LOG2-1){1'b0}}, 1'b1};
    wire [15:0] stack_top;

    return_stack #(.DEPTH_LOG2(STACK_LOG2)) u_stack
    (
        .aclk(aclk),
        .wr_en(eval_now),
        .wr_addr(sp_r),
        .wr_data(pc_out),
        .rd_addr(sp_dec),
        .rd_data(stack_top)
    );

    // ----------------------------------------------------------------
    // Vectoring and return
    // ----------------------------------------------------------------
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            hw_vector_call <= 1'b0;
            vector_source <= NO_SOURCE;
            pc_out <= `PC_RESET;
            pushed_pc <= `PC_RESET;
            low_active_r <= 1'b0;
            high_active_r <= 1'b0;
            sp_r <= {STACK_LOG2{1'b0}};
        end
        else
        begin
            hw_vector_call <= eval_now;
            if (eval_now)
            begin
                // Only the PC is pushed; status word left to software
                pushed_pc <= pc_out; // R15 R17
                pc_out <= vector_of(winner); // R13 R15
                vector_source <= winner;
                sp_r <= sp_r + {{(STACK_LOG2-1){1'b0}}, 1'b1};
                if (high_ok)
                    high_active_r <= 1'b1;
                else
                    low_active_r <= 1'b1;
            end
            else if (ret_now)
            begin
                pc_out <= stack_top;
                sp_r <= sp_dec;
                if (high_active_r)
                    high_active_r <= 1'b0; // R20
                else
                    low_active_r <= 1'b0;
            end
            else if (step_pending_r)
            begin
                pc_out <= pc_out + 16'h0001;
            end
        end
    end

    // ----------------------------------------------------------------
    // AXI4-Lite slave
    // ----------------------------------------------------------------
    // Both address and data must be present; taken together in one edge
    wire wr_take = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
    assign s_axi_awready = wr_take;
    assign s_axi_wready = wr_take;
    wire rd_take = s_axi_arvalid && !s_axi_rvalid;
    assign s_axi_arready = rd_take;

    wire [11:0] waddr = {s_axi_awaddr[11:2], 2'b00};
    wire [11:0] raddr = {s_axi_araddr[11:2], 2'b00};
    wire wr_hit = (waddr == `IRQ_ENABLE_OFFSET) || (waddr == `IRQ_LEVEL_OFFSET)
        || (waddr == `IRQ_CORE_OFFSET);

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            interrupt_enable_reg <= `IRQ_ENABLE_RESET;
            interrupt_priority_reg <= `IRQ_LEVEL_RESET;
            step_pending_r <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end
        else
        begin
            step_pending_r <= 1'b0;
            if (wr_take)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
                if (waddr == `IRQ_ENABLE_OFFSET)
                    interrupt_enable_reg <= merge_byte(interrupt_enable_reg,
                        s_axi_wdata[7:0], s_axi_wstrb[0], `IRQ_ENABLE_MASK); // R4
                if (waddr == `IRQ_LEVEL_OFFSET)
                    interrupt_priority_reg <= merge_byte(interrupt_priority_reg,
                        s_axi_wdata[7:0], s_axi_wstrb[0], `IRQ_LEVEL_MASK); // R5
                if (waddr == `IRQ_CORE_OFFSET && s_axi_wstrb[0])
                    step_pending_r <= s_axi_wdata[`CORE_STEP_BIT];
            end
            else if (s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= RESP_OKAY;
        end
        else if (rd_take)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            case (raddr)
                `IRQ_ENABLE_OFFSET: s_axi_rdata <= {24'h000000, interrupt_enable_reg};
                `IRQ_LEVEL_OFFSET: s_axi_rdata <= {24'h000000, interrupt_priority_reg};
                `IRQ_STATUS_OFFSET: s_axi_rdata <= {16'h0000, 3'h0, low_active_r,
                    high_active_r, vector_source, 3'h0, sampled_r};
                `IRQ_CORE_OFFSET: s_axi_rdata <= 32'h00000000;
                `IRQ_PC_OFFSET: s_axi_rdata <= {16'h0000, pc_out};
                `IRQ_STACK_OFFSET: s_axi_rdata <= {16'h0000, pushed_pc};
                default:
                begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end
        else if (s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule

// [verification/irq_ctrl_checker.sv]
// Concurrent checks on the interrupt controller ports
`timescale 1ns/1ps
module irq_ctrl_checker
(
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Request flags
    input wire ext0_req,
    input wire timer0_req,
    input wire ext1_req,
    input wire timer1_req,
    input wire serial_req,
    // Core side
    input wire hw_vector_call,
    input wire [2:0] vector_source,
    input wire [15:0] pc_out,
    input wire [15:0] pushed_pc,
    input wire [2:0] machine_state,
    input wire machine_phase2,
    // Register bus
    input wire s_axi_awready,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire [31:0] s_axi_rdata
);
    reg any_sampled_r;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Flags only count as seen at the state 5 capture edge
    always @(posedge aclk)
    begin
        if (!aresetn)
            any_sampled_r <= 1'b0;
        else if (machine_state == 3'd5 && machine_phase2)
            any_sampled_r <= ext0_req | timer0_req | ext1_req | timer1_req | serial_req;
    end
    a_call_single: assert property (hw_vector_call |=> !hw_vector_call)
        else $error("vector call wider than one cycle");
    a_vector_addr: assert property (hw_vector_call
        |-> vector_source <= 3'h4 && pc_out == {10'h000, vector_source, 3'h3})
        else $error("wrong vector address");
    a_push_pc: assert property (hw_vector_call |-> pushed_pc == $past(pc_out))
        else $error("pushed pc is not the old pc");
    a_call_sampled: assert property (hw_vector_call |-> any_sampled_r)
        else $error("call without a captured flag");
    a_call_state: assert property (hw_vector_call |-> machine_state == 3'd1)
        else $error("call outside the cycle boundary");
    a_phase_flip: assert property ($past(aresetn)
        |-> machine_phase2 != $past(machine_phase2))
        else $error("phase did not flip");
    a_state_step: assert property ($fell(machine_phase2)
        |-> machine_state == ($past(machine_state) == 3'h6 ? 3'h1 : $past(machine_state) + 3'h1))
        else $error("machine state did not advance");
    a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_read_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_ready_refuse: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("address taken while response pending");
endmodule
bind vectored_irq_controller irq_ctrl_checker u_chk (.aclk, .aresetn, .ext0_req, .timer0_req,
    .ext1_req, .timer1_req, .serial_req, .hw_vector_call, .vector_source, .pc_out, .pushed_pc,
    .machine_state, .machine_phase2, .s_axi_awready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata);

// [verification/request_sources.sv]
// Model of the timer, serial and external pin request flags
`timescale 1ns/1ps
module request_sources
(
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Commands from the bench
    input wire [4:0] set_mask,
    input wire [4:0] clr_mask,
    // Flags, bit 0 ext0 up to bit 4 serial
    output reg [4:0] flags
);
    // Flags stay up until cleared, as a routine clears its own source
    always @(posedge aclk)
    begin
        if (!aresetn)
            flags <= 5'h00;
        else
            flags <= (flags | set_mask) & ~clr_mask;
    end
endmodule

// [verification/test_vectored_irq_controller.sv]
// Self-checking bench for the vectored interrupt controller
`timescale 1ns/1ps
`include "irq_ctrl_map.vh"
module test_vectored_irq_controller;
    logic aclk, aresetn, return_from_irq, hw_vector_call, machine_phase2;
    logic [4:0] set_mask, clr_mask, flags;
    logic [2:0] vector_source, machine_state;
    logic [15:0] pc_out, pushed_pc, exp_pc;
    logic [15:0] stk [0:7];
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    integer n_fail, n_checks, sp, k;
    request_sources src_model (.aclk, .aresetn, .set_mask, .clr_mask, .flags);
    vectored_irq_controller dut (.aclk, .aresetn, .ext0_req(flags[0]), .timer0_req(flags[1]),
        .ext1_req(flags[2]), .timer1_req(flags[3]), .serial_req(flags[4]), .return_from_irq,
        .hw_vector_call, .vector_source, .pc_out, .pushed_pc, .machine_state, .machine_phase2,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf),
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    always #50 aclk = ~aclk;
    task check(input [31:0] seen, input [31:0] exp);
    begin
        n_checks = n_checks + 1;
        if (seen !== exp)
        begin
            n_fail = n_fail + 1;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    end
    endtask
    task give_verdict;
    begin
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    end
    endtask
    task hang;
    begin
        n_fail = n_fail + 1;
        $display("mismatch at %0t: wait timed out", $time);
        give_verdict;
    end
    endtask
    function [15:0] vec(input [2:0] s);
        case (s)
            3'd0: vec = `VEC_EXT0;
            3'd1: vec = `VEC_TIMER0;
            3'd2: vec = `VEC_EXT1;
            3'd3: vec = `VEC_TIMER1;
            default: vec = `VEC_SERIAL;
        endcase
    endfunction
    // Outputs are sampled at the falling edge, settled for the next rising edge
    task wr(input [11:0] a, input [31:0] d, input [1:0] exp);
        integer i;
        reg got_b, aw_hit, w_hit;
        reg [1:0] resp;
    begin
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        got_b = 1'b0;
        resp = 2'h0;
        for (i = 0; !got_b; i = i + 1)
        begin
            if (i > 50)
                hang;
            @(negedge aclk);
            aw_hit = (s_axi_awvalid === 1'b1) && (s_axi_awready === 1'b1);
            w_hit = (s_axi_wvalid === 1'b1) && (s_axi_wready === 1'b1);
            got_b = (s_axi_bvalid === 1'b1);
            resp = s_axi_bresp;
            @(posedge aclk);
            if (aw_hit)
                s_axi_awvalid <= 1'b0;
            if (w_hit)
                s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
        check(resp, exp);
        @(posedge aclk);
    end
    endtask
    task rd(input [11:0] a, input [31:0] exp, input [1:0] exp_resp);
        integer i;
        reg got_r, ar_hit;
        reg [1:0] resp;
        reg [31:0] data;
    begin
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        got_r = 1'b0;
        resp = 2'h0;
        data = 32'h0;
        for (i = 0; !got_r; i = i + 1)
        begin
            if (i > 50)
                hang;
            @(negedge aclk);
            ar_hit = (s_axi_arvalid === 1'b1) && (s_axi_arready === 1'b1);
            got_r = (s_axi_rvalid === 1'b1);
            resp = s_axi_rresp;
            data = s_axi_rdata;
            @(posedge aclk);
            if (ar_hit)
                s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
        check(resp, exp_resp);
        if (exp_resp == 2'b00)
            check(data, exp);
        @(posedge aclk);
    end
    endtask
    task drive_flags(input [4:0] s, input [4:0] c);
    begin
        set_mask <= s;
        clr_mask <= c;
        @(posedge aclk);
        set_mask <= 5'h00;
        clr_mask <= 5'h00;
    end
    endtask
    task wait_call(input [2:0] src);
        integer i;
    begin
        @(negedge aclk);
        for (i = 0; hw_vector_call !== 1'b1; i = i + 1)
        begin
            if (i > 60)
                hang;
            @(negedge aclk);
        end
        check(vector_source, src);
        check(pc_out, vec(src));
        check(pushed_pc, exp_pc);
        stk[sp] = exp_pc;
        sp = sp + 1;
        exp_pc = vec(src);
        @(posedge aclk);
    end
    endtask
    task no_call(input integer n);
        integer i, seen;
    begin
        seen = 0;
        for (i = 0; i < n; i = i + 1)
        begin
            @(negedge aclk);
            if (hw_vector_call !== 1'b0)
                seen = seen + 1;
        end
        check(seen, 0);
        @(posedge aclk);
    end
    endtask
    // Return is issued in state 2, far from the evaluation edge that would swallow it
    task ret;
        integer i;
    begin
        @(negedge aclk);
        for (i = 0; machine_state !== 3'h2; i = i + 1)
        begin
            if (i > 30)
                hang;
            @(negedge aclk);
        end
        @(posedge aclk);
        return_from_irq <= 1'b1;
        @(posedge aclk);
        return_from_irq <= 1'b0;
        repeat (3) @(posedge aclk);
        sp = sp - 1;
        exp_pc = stk[sp];
        check(pc_out, exp_pc);
    end
    endtask
    task t_regs;
    begin
        rd(`IRQ_ENABLE_OFFSET, `IRQ_ENABLE_RESET, 2'b00);
        rd(`IRQ_LEVEL_OFFSET, `IRQ_LEVEL_RESET, 2'b00);
        wr(`IRQ_ENABLE_OFFSET, 32'hff, 2'b00);
        rd(`IRQ_ENABLE_OFFSET, 32'h9f, 2'b00);
        wr(`IRQ_LEVEL_OFFSET, 32'hff, 2'b00);
        rd(`IRQ_LEVEL_OFFSET, 32'h1f, 2'b00);
        wr(`IRQ_LEVEL_OFFSET, 32'h00, 2'b00);
        wr(`IRQ_STATUS_OFFSET, 32'hff, 2'b10);
        rd(12'h100, 32'h0, 2'b10);
        // A single step makes the pushed counter differ from the reset value
        wr(`IRQ_CORE_OFFSET, 32'h2, 2'b00);
        exp_pc = exp_pc + 16'h0001;
        rd(`IRQ_PC_OFFSET, {16'h0000, exp_pc}, 2'b00);
        rd(`IRQ_CORE_OFFSET, 32'h0, 2'b00);
        $display("regs test done");
    end
    endtask
    task t_gate;
    begin
        wr(`IRQ_ENABLE_OFFSET, 32'h1f, 2'b00);
        drive_flags(5'h01, 5'h00);
        no_call(30);
        wr(`IRQ_ENABLE_OFFSET, 32'h80, 2'b00);
        no_call(30);
        wr(`IRQ_ENABLE_OFFSET, 32'h81, 2'b00);
        wait_call(3'd0);
        drive_flags(5'h00, 5'h01);
        ret;
        $display("gate test done");
    end
    endtask
    task t_poll;
    begin
        wr(`IRQ_ENABLE_OFFSET, 32'h9f, 2'b00);
        drive_flags(5'h1f, 5'h00);
        for (k = 0; k < 5; k = k + 1)
        begin
            wait_call(k[2:0]);
            drive_flags(5'h00, 5'h01 << k);
            no_call(30);
            ret;
        end
        $display("poll test done");
    end
    endtask
    task t_levels;
    begin
        wr(`IRQ_LEVEL_OFFSET, 32'h10, 2'b00);
        drive_flags(5'h11, 5'h00);
        wait_call(3'd4);
        drive_flags(5'h00, 5'h10);
        no_call(30);
        ret;
        wait_call(3'd0);
        wr(`IRQ_LEVEL_OFFSET, 32'h12, 2'b00);
        drive_flags(5'h02, 5'h01);
        wait_call(3'd1);
        rd(`IRQ_STACK_OFFSET, {16'h0000, stk[sp-1]}, 2'b00);
        drive_flags(5'h00, 5'h02);
        ret;
        ret;
        $display("levels test done");
    end
    endtask
    initial
    begin
        aclk = 1'b0;
        aresetn = 1'b0;
        return_from_irq = 1'b0;
        set_mask = 5'h00;
        clr_mask = 5'h00;
        s_axi_awaddr = 12'h000;
        s_axi_araddr = 12'h000;
        s_axi_wdata = 32'h0;
        s_axi_awvalid = 1'b0;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        n_fail = 0;
        n_checks = 0;
        sp = 0;
        exp_pc = `PC_RESET;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_regs;
        t_gate;
        t_poll;
        t_levels;
        give_verdict;
    end
endmodule
